// ---- rtl/fesp_map.vh ----
// Register map, field positions and reset values of the flash error/protection block
`ifndef FESP_MAP_VH
`define FESP_MAP_VH

// ***************************************
// Register byte offsets
// ***************************************
`define FESP_CFG_OFS 12'h004
`define FESP_ERR_OFS 12'h008
`define FESP_PROT_OFS 12'h00C
`define FESP_STAT_OFS 12'h010

// ***************************************
// Field positions
// ***************************************
`define FESP_SFIE_BIT 0
`define FESP_DFIE_BIT 1
`define FESP_IGN_BIT 4
`define FESP_SFLT_BIT 0
`define FESP_DFLT_BIT 1
`define FESP_VIOL_BIT 4
`define FESP_POPEN_BIT 7
`define FESP_RNV_BIT 6
`define FESP_HDIS_BIT 5
`define FESP_HS_MSB 4
`define FESP_HS_LSB 3
`define FESP_LDIS_BIT 2
`define FESP_LS_MSB 1
`define FESP_LS_LSB 0

// ***************************************
// Reset values and addresses
// ***************************************
`define FESP_CFG_RST 8'h00
`define FESP_ERR_RST 2'h0
`define FESP_PROT_FULL 8'h7F
`define FESP_HI_TOP 23'h7FFFFF
`define FESP_HI_BASE0 23'h7FF800
`define FESP_HI_BASE1 23'h7FF000
`define FESP_HI_BASE2 23'h7FE000
`define FESP_HI_BASE3 23'h7FC000
`define FESP_LO_BASE 23'h7F8000
`define FESP_LO_END0 23'h7F83FF
`define FESP_LO_END1 23'h7F87FF
`define FESP_LO_END2 23'h7F8FFF
`define FESP_LO_END3 23'h7F9FFF

`endif

// ---- rtl/fesp_range_check.v ----
// Decides whether a program-flash address is protected under a protection byte
`include "fesp_map.vh"
`default_nettype none

module fesp_range_check
(
   // Protection setting
   input wire [7:0] prot,
   // Address under test
   input wire [22:0] addr,
   output reg is_protected
);

   reg [22:0] hi_base;
   reg [22:0] lo_end;
   reg in_hi;
   reg in_lo;

   always @*
   begin
      case (prot[`FESP_HS_MSB:`FESP_HS_LSB])
         2'h0: hi_base = `FESP_HI_BASE0;
         2'h1: hi_base = `FESP_HI_BASE1;
         2'h2: hi_base = `FESP_HI_BASE2;
         default: hi_base = `FESP_HI_BASE3;
      endcase
      case (prot[`FESP_LS_MSB:`FESP_LS_LSB])
         2'h0: lo_end = `FESP_LO_END0;
         2'h1: lo_end = `FESP_LO_END1;
         2'h2: lo_end = `FESP_LO_END2;
         default: lo_end = `FESP_LO_END3;
      endcase
      // Range hit counts only when its disable bit is clear
      in_hi = !prot[`FESP_HDIS_BIT] && (addr >= hi_base) && (addr <= `FESP_HI_TOP);
      in_lo = !prot[`FESP_LDIS_BIT] && (addr >= `FESP_LO_BASE) && (addr <= lo_end);
      // Open mode: ranges are protected; closed mode: ranges are the only holes
      if (prot[`FESP_POPEN_BIT])
         is_protected = in_hi || in_lo;
      else
         is_protected = !(in_hi || in_lo);
   end

endmodule

`default_nettype wire

// ---- rtl/fesp_prot_guard.v ----
// Accepts a protection write only when the protected region does not shrink
`include "fesp_map.vh"
`default_nettype none

module fesp_prot_guard
(
   // Current and written protection bytes
   input wire [7:0] cur,
   input wire [7:0] wr,
   // Merged candidate and its acceptance
   output reg [7:0] cand,
   output reg accept
);

   reg h_old;
   reg l_old;
   reg h_new;
   reg l_new;

   always @*
   begin
      cand = cur;
      cand[`FESP_POPEN_BIT] = wr[`FESP_POPEN_BIT];
      cand[`FESP_HDIS_BIT] = wr[`FESP_HDIS_BIT];
      cand[`FESP_LDIS_BIT] = wr[`FESP_LDIS_BIT];
      // Size fields move only while their range is disabled
      if (cur[`FESP_HDIS_BIT])
         cand[`FESP_HS_MSB:`FESP_HS_LSB] = wr[`FESP_HS_MSB:`FESP_HS_LSB];
      if (cur[`FESP_LDIS_BIT])
         cand[`FESP_LS_MSB:`FESP_LS_LSB] = wr[`FESP_LS_MSB:`FESP_LS_LSB];
      h_old = !cur[`FESP_HDIS_BIT];
      l_old = !cur[`FESP_LDIS_BIT];
      h_new = !cand[`FESP_HDIS_BIT];
      l_new = !cand[`FESP_LDIS_BIT];
      // High and low ranges never overlap, so per-range checks suffice
      case ({cur[`FESP_POPEN_BIT], cand[`FESP_POPEN_BIT]})
         2'b11: accept = (!h_old || h_new) && (!l_old || l_new);
         2'b10: accept = (!h_old || !h_new) && (!l_old || !l_new);
         2'b00: accept = (h_old || !h_new) && (l_old || !l_new);
         default: accept = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

// ---- rtl/fesp_top.v ----
// Flash error flags and program-flash protection register with APB access
// ***************************************
// How it works
// - Double-fault flag sets on uncorrectable read or read of busy block.
// - Double-fault flag clears only on a written one.
// - Single-fault flag sets on corrected read or busy read unless ignored.
// - Single-fault flag clears only on a written one.
// - Error flags read back; writes can only clear them.
// - Protection writes take effect only if protection does not shrink.
// - Protection register loads from the nonvolatile byte during reset.
// - Double fault on that load gives full protection, open bit clear.
// - Program or erase of protected address is refused, violation flag set.
// - Block erase refused when any sector of the block is protected.
// - Open bit chooses protected ranges (1) or unprotected ranges (0).
// - High-range disable bit 5 turns off the range ending at top.
// - High size field writable only while high range disabled.
// - Low-range disable bit 2 turns off the range from base.
// - Low size field writable only while low range disabled.
// - Open with both disabled: nothing protected; closed: all protected.
// - Closed with a range enabled: only enabled ranges programmable.
// - Each fault flag requests an interrupt while its enable is set.
// ***************************************
//
// Decided for this implementation: register access over APB.
`include "fesp_map.vh"
`default_nettype none

module fesp_top
#(
   parameter AW = 12
)
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Nonvolatile load during reset sequence
   input wire nv_load,
   input wire [7:0] nv_byte,
   input wire nv_double_err,
   // Array read results
   input wire rd_done,
   input wire rd_single_err,
   input wire rd_double_err,
   input wire rd_busy_block,
   // Program and erase requests
   input wire pe_req,
   input wire pe_block_erase,
   input wire [22:0] pe_addr,
   output reg pe_grant,
   output reg pe_refuse,
   // Status outputs
   output reg protection_violation_flag,
   output reg double_fault_irq,
   output reg single_fault_irq,
   output reg [7:0] prot_out
);

   // ***************************************
   // Register state
   // ***************************************
   reg [7:0] flash_config_register;
   reg double_fault_flag;
   reg single_fault_flag;
   reg [7:0] program_flash_protection;
   reg viol;

   reg [31:0] next_rdata;
   reg next_err;
   reg next_double;
   reg next_single;
   reg next_viol;
   reg [7:0] next_prot;

   // Next values of the configuration register and of the bus, grant, refuse and interrupt outputs
   reg [7:0] next_cfg;
   reg next_ready;
   reg next_slverr;
   reg [31:0] next_prdata;
   reg next_grant;
   reg next_refuse;
   reg next_dirq;
   reg next_sirq;

   wire setup = psel && !penable;
   wire acc_done = psel && penable && pready;
   wire wr_done = acc_done && pwrite && !pslverr && pstrb[0];
   wire ign = flash_config_register[`FESP_IGN_BIT];
   wire dfie = flash_config_register[`FESP_DFIE_BIT];
   wire sfie = flash_config_register[`FESP_SFIE_BIT];

   // Full address compare, so aliases of the four registers answer with an error
   wire hit_cfg = (paddr == `FESP_CFG_OFS);
   wire hit_err = (paddr == `FESP_ERR_OFS);
   wire hit_prot = (paddr == `FESP_PROT_OFS);
   wire hit_stat = (paddr == `FESP_STAT_OFS);
   wire mapped = hit_cfg || hit_err || hit_prot || hit_stat;

   // ***************************************
   // Protection helpers
   // ***************************************
   wire addr_prot;
   wire [7:0] cand;
   wire accept;

   fesp_range_check u_range
   (
      .prot(program_flash_protection),
      .addr(pe_addr),
      .is_protected(addr_prot)
   );

   fesp_prot_guard u_guard
   (
      .cur(program_flash_protection),
      .wr(pwdata[7:0]),
      .cand(cand),
      .accept(accept)
   );

   // Any sector protected unless open mode with both ranges off
   wire block_prot = !(program_flash_protection[`FESP_POPEN_BIT] &&
                       program_flash_protection[`FESP_HDIS_BIT] &&
                       program_flash_protection[`FESP_LDIS_BIT]);
   wire pe_bad = pe_block_erase ? block_prot : addr_prot;

   // ***************************************
   // Read mux
   // ***************************************
   always @*
   begin
      next_rdata = 32'h00000000;
      next_err = !mapped;
      if (hit_cfg)
         next_rdata[7:0] = flash_config_register;
      if (hit_err)
      begin
         next_rdata[`FESP_DFLT_BIT] = double_fault_flag;
         next_rdata[`FESP_SFLT_BIT] = single_fault_flag;
      end
      if (hit_prot)
         next_rdata[7:0] = program_flash_protection;
      if (hit_stat)
         next_rdata[`FESP_VIOL_BIT] = viol;
   end

   // ***************************************
   // Next-state of flags and protection
   // ***************************************
   always @*
   begin
      next_double = double_fault_flag;
      next_single = single_fault_flag;
      next_viol = viol;
      next_prot = program_flash_protection;
      // Clears first so that a same-cycle event still wins
      if (wr_done && hit_err && pwdata[`FESP_DFLT_BIT])
         next_double = 1'b0;
      if (wr_done && hit_err && pwdata[`FESP_SFLT_BIT])
         next_single = 1'b0;
      if (wr_done && hit_stat && pwdata[`FESP_VIOL_BIT])
         next_viol = 1'b0;
      if (wr_done && hit_prot && accept)
         next_prot = cand;
      if (rd_done && (rd_double_err || rd_busy_block))
         next_double = 1'b1;
      if (rd_done && !ign && (rd_single_err || rd_busy_block))
         next_single = 1'b1;
      if (pe_req && pe_bad)
         next_viol = 1'b1;
      // The load is the reset sequence and overrides any software write
      if (nv_load)
      begin
         if (nv_double_err)
         begin
            next_prot = `FESP_PROT_FULL;
            next_double = 1'b1;
         end
         else
            next_prot = nv_byte;
      end
   end

   // ***************************************
   // APB handshake
   // ***************************************
   // Ready is registered from the setup phase, so no wait state and every bus output from a flip-flop
   always @*
   begin
      next_ready = setup;
      // Response holds between transfers; only setup and completion move it
      next_slverr = pslverr;
      next_prdata = prdata;
      if (setup)
      begin
         next_slverr = next_err;
         // Writes return zero so stale register data never reaches the bus
         next_prdata = pwrite ? 32'h00000000 : next_rdata;
      end
      else if (acc_done)
      begin
         next_slverr = 1'b0;
         next_prdata = 32'h00000000;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= next_ready;
         pslverr <= next_slverr;
         prdata <= next_prdata;
      end
   end

   // ***************************************
   // Configuration register
   // ***************************************
   // Only the three assigned bits take write data
   always @*
   begin
      next_cfg = flash_config_register;
      if (wr_done && hit_cfg)
      begin
         // Unassigned bits are kept at zero so reads show no stray state
         next_cfg = 8'h00;
         next_cfg[`FESP_IGN_BIT] = pwdata[`FESP_IGN_BIT];
         next_cfg[`FESP_DFIE_BIT] = pwdata[`FESP_DFIE_BIT];
         next_cfg[`FESP_SFIE_BIT] = pwdata[`FESP_SFIE_BIT];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flash_config_register <= `FESP_CFG_RST;
      else
         flash_config_register <= next_cfg;
   end

   // ***************************************
   // Error flags, violation and protection
   // ***************************************
   // Protection rests fully closed until the nonvolatile load arrives
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         double_fault_flag <= 1'b0;
         single_fault_flag <= 1'b0;
         viol <= 1'b0;
         program_flash_protection <= `FESP_PROT_FULL;
      end
      else
      begin
         double_fault_flag <= next_double;
         single_fault_flag <= next_single;
         viol <= next_viol;
         program_flash_protection <= next_prot;
      end
   end

   // ***************************************
   // Program and erase gate
   // ***************************************
   // Decided on the live register; the prot_out copy lags by a cycle
   always @*
   begin
      next_grant = 1'b0;
      next_refuse = 1'b0;
      if (pe_req)
      begin
         // Exactly one answer per request, never both
         if (pe_bad)
            next_refuse = 1'b1;
         else
            next_grant = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pe_grant <= 1'b0;
         pe_refuse <= 1'b0;
      end
      else
      begin
         pe_grant <= next_grant;
         pe_refuse <= next_refuse;
      end
   end

   // ***************************************
   // Registered status outputs
   // ***************************************
   // Outputs lag the flags by one cycle so each comes from a flip-flop
   // Masking here leaves the flags themselves untouched by the enables
   always @*
   begin
      next_dirq = double_fault_flag && dfie;
      next_sirq = single_fault_flag && sfie;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         double_fault_irq <= 1'b0;
         single_fault_irq <= 1'b0;
         protection_violation_flag <= 1'b0;
         prot_out <= `FESP_PROT_FULL;
      end
      else
      begin
         double_fault_irq <= next_dirq;
         single_fault_irq <= next_sirq;
         protection_violation_flag <= viol;
         prot_out <= program_flash_protection;
      end
   end

endmodule

`default_nettype wire

// ---- sim/fesp_chk.sv ----
// Assertion checker for the flash error and protection block
`default_nettype none
module fesp_chk
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Observed ports
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic nv_load,
   input wire logic nv_double_err,
   input wire logic pe_req,
   input wire logic pe_block_erase,
   input wire logic pe_grant,
   input wire logic pe_refuse,
   input wire logic protection_violation_flag,
   input wire logic double_fault_irq,
   input wire logic single_fault_irq,
   input wire logic [7:0] prot_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire wr_acc;
   wire open_all;
   assign wr_acc = psel && penable && pwrite;
   // prot_out lags, so a fresh nonvolatile load is kept out of erase checks
   assign open_all = prot_out[7] && prot_out[5] && prot_out[2];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_dirq_hold: assert property (double_fault_irq && !wr_acc && !$past(wr_acc)
      |=> double_fault_irq)
      else $error("double fault request dropped without a write");
   a_sirq_hold: assert property (single_fault_irq && !wr_acc && !$past(wr_acc)
      |=> single_fault_irq)
      else $error("single fault request dropped without a write");
   a_viol_set: assert property (pe_refuse |=> protection_violation_flag)
      else $error("refused request left violation flag clear");
   a_viol_hold: assert property (protection_violation_flag && !wr_acc && !$past(wr_acc)
      |=> protection_violation_flag)
      else $error("violation flag dropped without a write");
   a_pe_answer: assert property (pe_req |=> pe_grant ^ pe_refuse)
      else $error("request not answered by exactly one of grant or refuse");
   a_pe_cause: assert property (pe_grant || pe_refuse |-> $past(pe_req))
      else $error("answer without request");
   a_blk_erase: assert property (pe_req && pe_block_erase && !open_all && !nv_load
      && !$past(nv_load) |=> pe_refuse)
      else $error("block erase granted under protection");
   a_full_prot: assert property (pe_req && !prot_out[7] && prot_out[5] && prot_out[2] && !nv_load
      && !$past(nv_load) |=> pe_refuse)
      else $error("request granted under full protection");
   a_nv_fault: assert property (nv_load && nv_double_err |=> ##1 prot_out == 8'h7F)
      else $error("faulty load did not give full protection");
endmodule
bind fesp_top fesp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .nv_load(nv_load), .nv_double_err(nv_double_err), .pe_req(pe_req),
   .pe_block_erase(pe_block_erase), .pe_grant(pe_grant), .pe_refuse(pe_refuse),
   .protection_violation_flag(protection_violation_flag), .double_fault_irq(double_fault_irq),
   .single_fault_irq(single_fault_irq), .prot_out(prot_out));
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the flash error and protection block
`include "fesp_map.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, se, nv_load = 0, nv_double_err = 0;
   logic [3:0] pstrb = 4'hF;
   logic [7:0] nv_byte = 8'h00, prot_out;
   logic rd_done = 0, rd_single_err = 0, rd_double_err = 0, rd_busy_block = 0;
   logic pe_req = 0, pe_block_erase = 0, pe_grant, pe_refuse, viol, dirq, sirq;
   logic [22:0] pe_addr = 23'h0;
   int err_total = 0, checks = 0;
   localparam logic [11:0] PR = `FESP_PROT_OFS, ER = `FESP_ERR_OFS;
   localparam logic [11:0] ST = `FESP_STAT_OFS, CF = `FESP_CFG_OFS;
   always #4 pclk = ~pclk;
   fesp_top #(.AW(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nv_load(nv_load), .nv_byte(nv_byte),
      .nv_double_err(nv_double_err), .rd_done(rd_done), .rd_single_err(rd_single_err),
      .rd_double_err(rd_double_err), .rd_busy_block(rd_busy_block), .pe_req(pe_req),
      .pe_block_erase(pe_block_erase), .pe_addr(pe_addr), .pe_grant(pe_grant),
      .pe_refuse(pe_refuse), .protection_violation_flag(viol), .double_fault_irq(dirq),
      .single_fault_irq(sirq), .prot_out(prot_out));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      // A transfer that never completes is a failure, not a silent pass
      if (pready !== 1'b1)
         err_total++;
      q = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask
   // Bit 6 is the RNV bit loaded from the nonvolatile byte, so it is left out of every register compare
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk($sformatf("reg %h", a), e, q & 32'hFFFFFFBF);
   endtask
   task automatic pe(input logic [22:0] a, input logic b, input logic [1:0] e);
      @(posedge pclk);
      pe_req <= 1;
      pe_addr <= a;
      pe_block_erase <= b;
      @(posedge pclk);
      pe_req <= 0;
      @(posedge pclk);
      chk($sformatf("grant refuse %h", a), e, {pe_grant, pe_refuse});
   endtask
   task automatic nvl(input logic [7:0] v, input logic f);
      @(posedge pclk);
      nv_load <= 1;
      nv_byte <= v;
      nv_double_err <= f;
      @(posedge pclk);
      nv_load <= 0;
   endtask
   task automatic rdf(input logic s, input logic d, input logic b);
      @(posedge pclk);
      rd_done <= 1;
      rd_single_err <= s;
      rd_double_err <= d;
      rd_busy_block <= b;
      @(posedge pclk);
      rd_done <= 0;
   endtask
   task automatic end_of_test;
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #100us;
      err_total++;
      end_of_test;
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      rdc(ER, 32'h0);
      rdc(PR, 32'h3F);
      nvl(8'hE4, 0);
      rdc(PR, 32'hA4);
      chk("prot out", 32'hE4, prot_out);
      pe(23'h7F8000, 1, 2'b10);
      pe(23'h7FFFFF, 0, 2'b10);
      wr(PR, 32'hED);
      rdc(PR, 32'hAD);
      wr(PR, 32'hA9);
      rdc(PR, 32'hA9);
      pe(23'h7F87FF, 0, 2'b01);
      pe(23'h7F8800, 0, 2'b10);
      pe(23'h7FC000, 1, 2'b01);
      rdc(ST, 32'h10);
      chk("violation flag", 1, viol);
      wr(ST, 32'h10);
      rdc(ST, 32'h0);
      chk("violation flag", 0, viol);
      wr(PR, 32'hAB);
      rdc(PR, 32'hA9);
      wr(PR, 32'hAD);
      rdc(PR, 32'hA9);
      wr(PR, 32'h89);
      pe(23'h7FF000, 0, 2'b01);
      pe(23'h7FEFFF, 0, 2'b10);
      nvl(8'h59, 0);
      pe(23'h7FC000, 0, 2'b10);
      pe(23'h7FBFFF, 0, 2'b01);
      pe(23'h7F87FF, 0, 2'b10);
      wr(PR, 32'h5D);
      rdc(PR, 32'h1D);
      pe(23'h7F8000, 0, 2'b01);
      nvl(8'h00, 1);
      rdc(PR, 32'h3F);
      rdc(ER, 32'h2);
      pe(23'h7FF000, 0, 2'b01);
      wr(ER, 32'h3);
      wr(CF, 32'h3);
      rdf(1, 0, 0);
      rdc(ER, 32'h1);
      chk("single irq", 1, sirq);
      wr(ER, 32'h0);
      rdc(ER, 32'h1);
      wr(ER, 32'h1);
      rdc(ER, 32'h0);
      rdf(0, 1, 0);
      rdc(ER, 32'h2);
      chk("double irq", 1, dirq);
      wr(ER, 32'h1);
      rdc(ER, 32'h2);
      wr(ER, 32'h2);
      rdc(ER, 32'h0);
      rdf(0, 0, 1);
      rdc(ER, 32'h3);
      wr(ER, 32'h3);
      wr(ER, 32'h3);
      rdc(ER, 32'h0);
      wr(CF, 32'h13);
      rdf(1, 0, 0);
      rdc(ER, 32'h0);
      rdf(0, 0, 1);
      rdc(ER, 32'h2);
      wr(12'h03C, 32'h3);
      chk("pslverr", 1, se);
      rdc(ER, 32'h2);
      // A write with the low byte lane off must not touch the flags
      pstrb <= 4'h0;
      wr(ER, 32'h2);
      pstrb <= 4'hF;
      rdc(ER, 32'h2);
      wr(CF, 32'h0);
      rdc(ER, 32'h2);
      chk("double irq", 0, dirq);
      end_of_test;
   end
endmodule
`default_nettype wire
